// ### design/encoder_out_pkg.sv
// Shared constants and types for the encoder pulse output stage
package encoder_out_pkg;

	// Datapath widths
	localparam int PPR_W   = 19;
	localparam int RATIO_W = 23;
	localparam int POS_W   = 20;
	localparam int ACC_W   = 24;
	localparam int CNT_W   = 16;

	// Output pulses per revolution limits and default
	localparam logic [PPR_W-1:0] PPR_MIN     = 19'h00010;
	localparam logic [PPR_W-1:0] PPR_MAX_20  = 19'h40000;
	localparam logic [PPR_W-1:0] PPR_MAX_18  = 19'h10000;
	localparam logic [PPR_W-1:0] PPR_DEFAULT = 19'h00800;
	localparam logic [PPR_W-1:0] PPR_RATIO   = 19'h00000;

	// Output ratio limits and defaults
	localparam logic [RATIO_W-1:0] RATIO_MIN   = 23'h000001;
	localparam logic [RATIO_W-1:0] RATIO_MAX   = 23'h400000;
	localparam logic [RATIO_W-1:0] NUM_DEFAULT = 23'h000001;
	localparam logic [RATIO_W-1:0] DEN_DEFAULT = 23'h000010;

	// Encoder counts per revolution
	localparam logic [ACC_W-1:0] RES_20 = 24'h100000;
	localparam logic [ACC_W-1:0] RES_18 = 24'h040000;

	// Highest position, also the position wrap mask
	localparam logic [POS_W-1:0] POS_MAX_20 = 20'hFFFFF;
	localparam logic [POS_W-1:0] POS_MAX_18 = 20'h3FFFF;
	localparam logic [POS_W-1:0] POS_ONE    = 20'h00001;
	localparam logic [POS_W-1:0] OFFS_DEFAULT = 20'h00000;

	// Host counts four edges per output pulse
	localparam logic [ACC_W-1:0] QUAD_EDGES = 24'h000004;

	// Setting encodings
	localparam logic LEAD_B_AT_CCW = 1'b0;
	localparam logic FWD_IS_CCW    = 1'b0;

	// Asynchronous index pulse width in ratio mode
	localparam int CLK_MHZ     = 50;
	localparam int Z_PULSE_US  = 125;
	localparam int Z_PULSE_CYC = Z_PULSE_US * CLK_MHZ;

	// Index window state in pulses-per-revolution mode
	typedef enum logic [2:0] {
		Z_IDLE  = 3'b001,
		Z_ARMED = 3'b010,
		Z_HIGH  = 3'b100
	} z_state_t;

endpackage

// ### design/frac_step_divider.sv
// Fractional step divider: inc/mod output steps per input step, reversible
`timescale 1ns/1ps
module frac_step_divider import encoder_out_pkg::*; (
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             rst_b_i,
	// Ratio, inc never above mod
	input  wire logic [ACC_W-1:0] inc_i,
	input  wire logic [ACC_W-1:0] mod_i,
	input  wire logic             clear_i,
	// Input steps
	input  wire logic             step_i,
	input  wire logic             ccw_i,
	// Output steps
	output logic                  step_o,
	output logic                  ccw_o
);

	logic [ACC_W-1:0] acc_r;
	logic [ACC_W-1:0] acc_nxt;
	logic             step_nxt;
	logic             ccw_nxt;
	logic [ACC_W:0]   sum;

	// Accumulate; reverse steps undo forward ones exactly, so no drift
	always_comb begin
		sum      = {1'b0, acc_r} + {1'b0, inc_i};
		acc_nxt  = acc_r;
		step_nxt = 1'b0;
		ccw_nxt  = ccw_o;
		if (clear_i) begin
			acc_nxt = '0;
		end else if (step_i && ccw_i) begin
			ccw_nxt = 1'b1;
			if (sum >= {1'b0, mod_i}) begin
				acc_nxt  = ACC_W'(sum - {1'b0, mod_i});
				step_nxt = 1'b1;
			end else begin
				acc_nxt = ACC_W'(sum);
			end
		end else if (step_i) begin
			ccw_nxt = 1'b0;
			if (acc_r >= inc_i) begin
				acc_nxt = acc_r - inc_i;
			end else begin
				acc_nxt  = ACC_W'(({1'b0, acc_r} + {1'b0, mod_i}) - {1'b0, inc_i});
				step_nxt = 1'b1;
			end
		end
	end

	// Register accumulator and step
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			acc_r  <= '0;
			step_o <= 1'b0;
			ccw_o  <= 1'b0;
		end else begin
			acc_r  <= acc_nxt;
			step_o <= step_nxt;
			ccw_o  <= ccw_nxt;
		end
	end

	// [R15] output only follows input
	a_step_has_cause: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R15]
		step_o |-> $past(step_i) && !$past(clear_i))
		else $error("output step without input step");

	// [R15] remainder stays below modulus while running
	a_acc_in_range: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R15]
		!clear_i |-> acc_r < mod_i)
		else $error("divider remainder out of range");

endmodule // frac_step_divider

// ### design/pulse_timer.sv
// Fixed-width pulse timer, retriggers ignored while running
`timescale 1ns/1ps
module pulse_timer import encoder_out_pkg::*; #(
	parameter int WIDTH_CYC = Z_PULSE_CYC
) (
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_b_i,
	// Trigger and pulse
	input  wire logic trig_i,
	output logic      pulse_o
);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;

	// Load on trigger when idle, count down otherwise
	always_comb begin
		cnt_nxt = cnt_r;
		if (cnt_r != '0) begin
			cnt_nxt = cnt_r - 1'b1;
		end else if (trig_i) begin
			cnt_nxt = CNT_W'(WIDTH_CYC);
		end
	end

	// Pulse is registered from the next count
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r   <= '0;
			pulse_o <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			pulse_o <= (cnt_nxt != '0);
		end
	end

	// [R6] pulse opens at full width
	a_pulse_full_len: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R6]
		$rose(pulse_o) |-> cnt_r == CNT_W'(WIDTH_CYC) ##1 pulse_o[*4])
		else $error("index pulse shorter than set width");

endmodule // pulse_timer

// ### design/encoder_pulse_output_divider.sv
// Encoder emulation output: divided A/B quadrature and Z index pulses
//
// Operation
// [R1] Per-revolution mode emits the set pulse count per revolution on A and B.
// [R2] Count clamped to 16..262144 (20-bit) or 16..65536 (18-bit).
// [R3] Host counts every A/B edge, four counts per output pulse.
// [R4] Nonzero count setting: Z aligned with A, same width as A pulse.
// [R5] Zero count setting: rate scaled by numerator/denominator, each 1..4194304.
// [R6] Ratio mode: Z is asynchronous with fixed 125 us width.
// [R7] Numerator above denominator gives a ratio of exactly one.
// [R8] Lead setting 0: B leads A at CCW; 1: A leads B.
// [R9] Z shifted CCW by offset, at most 1048575 or 262143.
// [R10] Offset ignores the rotation direction setting, always counted CCW.
// [R11] Homing uses the offset-shifted index position.
// [R12] Encoder resolution is 262144 or 1048576 counts per revolution.
// [R13] Direction setting 0: forward is CCW; 1: forward is CW.
// [R14] Settings are taken once after reset release and then held.
// [R15] Ratio mode pulses equal counts/4 times numerator over denominator.
`timescale 1ns/1ps
module encoder_pulse_output_divider import encoder_out_pkg::*; #(
	parameter int Z_PULSE_CYCLES = Z_PULSE_CYC
) (
	// Clock and reset
	input  wire logic               clk_sys_i,
	input  wire logic               rst_b_i,
	// Power-up settings
	input  wire logic               enc_is_20bit_i,
	input  wire logic [PPR_W-1:0]   output_pulses_per_rev_i,
	input  wire logic [RATIO_W-1:0] output_ratio_numerator_i,
	input  wire logic [RATIO_W-1:0] output_ratio_denominator_i,
	input  wire logic               ccw_phase_lead_select_i,
	input  wire logic [POS_W-1:0]   index_position_offset_i,
	input  wire logic               rotation_direction_select_i,
	// Encoder position, counts up in CCW rotation
	input  wire logic [POS_W-1:0]   enc_pos_i,
	// Motion command direction
	input  wire logic               forward_cmd_i,
	// Quadrature outputs to the control connector
	output logic                    quad_out_a_pos_o,
	output logic                    quad_out_a_neg_o,
	output logic                    quad_out_b_pos_o,
	output logic                    quad_out_b_neg_o,
	output logic                    index_out_pos_o,
	output logic                    index_out_neg_o,
	// Homing reference and status
	output logic [POS_W-1:0]        home_ref_pos_o,
	output logic                    home_index_o,
	output logic                    rotate_ccw_o,
	output logic                    cfg_ready_o
);

	// Held settings
	logic               loaded_r,   loaded_nxt;
	logic               is20_r,     is20_nxt;
	logic               per_rev_r,  per_rev_nxt;
	logic [PPR_W-1:0]   ppr_r,      ppr_nxt;
	logic [ACC_W-1:0]   inc_r,      inc_nxt;
	logic [ACC_W-1:0]   mod_r,      mod_nxt;
	logic               lead_r,     lead_nxt;
	logic [POS_W-1:0]   offs_r,     offs_nxt;
	logic               dir_sel_r,  dir_sel_nxt;
	// Clamp helpers
	logic [PPR_W-1:0]   ppr_max;
	logic [PPR_W-1:0]   ppr_c;
	logic [RATIO_W-1:0] num_c;
	logic [RATIO_W-1:0] den_c;
	logic [POS_W-1:0]   offs_max;
	// Position tracking
	logic [POS_W-1:0]   mask;
	logic [POS_W-1:0]   pos_m;
	logic [POS_W-1:0]   diff;
	logic [POS_W-1:0]   prev_r,     prev_nxt;
	logic               enc_step;
	logic               enc_ccw;
	logic               index_evt;
	// Quadrature and index
	logic               div_step;
	logic               div_ccw;
	logic [1:0]         ph_r,       ph_nxt;
	logic               a_r,        a_nxt;
	logic               b_r,        b_nxt;
	z_state_t           z_state_r,  z_state_nxt;
	logic               z_r,        z_nxt;
	logic               z_async;
	logic               home_nxt;
	logic               ccw_nxt;

	// Setting clamps, evaluated from the pins until the settings are taken
	always_comb begin
		ppr_max  = enc_is_20bit_i ? PPR_MAX_20 : PPR_MAX_18;
		offs_max = enc_is_20bit_i ? POS_MAX_20 : POS_MAX_18;
		// [R2] clamp pulse count
		ppr_c = (output_pulses_per_rev_i < PPR_MIN) ? PPR_MIN :
			(output_pulses_per_rev_i > ppr_max) ? ppr_max : output_pulses_per_rev_i;
		// [R5] clamp ratio terms; out-of-range values are pulled in, not refused
		num_c = (output_ratio_numerator_i < RATIO_MIN) ? RATIO_MIN :
			(output_ratio_numerator_i > RATIO_MAX) ? RATIO_MAX : output_ratio_numerator_i;
		den_c = (output_ratio_denominator_i < RATIO_MIN) ? RATIO_MIN :
			(output_ratio_denominator_i > RATIO_MAX) ? RATIO_MAX : output_ratio_denominator_i;
	end

	// Settings taken once, at the first edge after reset release
	always_comb begin
		loaded_nxt  = 1'b1;
		is20_nxt    = is20_r;
		per_rev_nxt = per_rev_r;
		ppr_nxt     = ppr_r;
		inc_nxt     = inc_r;
		mod_nxt     = mod_r;
		lead_nxt    = lead_r;
		offs_nxt    = offs_r;
		dir_sel_nxt = dir_sel_r;
		// [R14] sample once, hold
		if (!loaded_r) begin
			is20_nxt    = enc_is_20bit_i;
			per_rev_nxt = (output_pulses_per_rev_i != PPR_RATIO);
			ppr_nxt     = ppr_c;
			lead_nxt    = ccw_phase_lead_select_i;
			dir_sel_nxt = rotation_direction_select_i;
			// [R9] offset limited per encoder
			offs_nxt    = (index_position_offset_i > offs_max) ? offs_max :
				index_position_offset_i;
			if (per_rev_nxt) begin
				// [R1] four edges per pulse against one revolution
				inc_nxt = ACC_W'(ppr_c) * QUAD_EDGES;
				// [R12] resolution by encoder type
				mod_nxt = enc_is_20bit_i ? RES_20 : RES_18;
			end else begin
				// [R7] ratio capped at one
				inc_nxt = (num_c > den_c) ? ACC_W'(den_c) : ACC_W'(num_c);
				// [R15] one edge per count times num/den
				mod_nxt = ACC_W'(den_c);
			end
		end
	end

	// Register settings; reset values are the usual defaults
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			loaded_r  <= 1'b0;
			is20_r    <= 1'b1;
			per_rev_r <= 1'b1;
			ppr_r     <= PPR_DEFAULT;
			inc_r     <= '0;
			mod_r     <= RES_20;
			lead_r    <= LEAD_B_AT_CCW;
			offs_r    <= OFFS_DEFAULT;
			dir_sel_r <= FWD_IS_CCW;
		end else begin
			loaded_r  <= loaded_nxt;
			is20_r    <= is20_nxt;
			per_rev_r <= per_rev_nxt;
			ppr_r     <= ppr_nxt;
			inc_r     <= inc_nxt;
			mod_r     <= mod_nxt;
			lead_r    <= lead_nxt;
			offs_r    <= offs_nxt;
			dir_sel_r <= dir_sel_nxt;
		end
	end

	// Position step detection; jumps of more than one count resync silently
	always_comb begin
		mask      = loaded_r ? (is20_r ? POS_MAX_20 : POS_MAX_18) :
			(enc_is_20bit_i ? POS_MAX_20 : POS_MAX_18);
		pos_m     = enc_pos_i & mask;
		diff      = (pos_m - prev_r) & mask;
		enc_step  = loaded_r && ((diff == POS_ONE) || (diff == mask));
		enc_ccw   = (diff == POS_ONE);
		prev_nxt  = pos_m;
		// [R10] fixed CCW position, direction setting not involved
		index_evt = enc_step && (pos_m == offs_r);
	end

	// Fractional divider from encoder counts to quadrature edges
	frac_step_divider u_div (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.inc_i     (inc_r),
		.mod_i     (mod_r),
		.clear_i   (!loaded_r),
		.step_i    (enc_step),
		.ccw_i     (enc_ccw),
		.step_o    (div_step),
		.ccw_o     (div_ccw)
	);

	// Quadrature phase; bit1^bit0 leads bit1 when counting up
	always_comb begin
		ph_nxt = ph_r;
		if (div_step) begin
			ph_nxt = div_ccw ? ph_r + 2'b01 : ph_r - 2'b01;
		end
		// [R8] lead phase select
		if (lead_r == LEAD_B_AT_CCW) begin
			a_nxt = ph_nxt[1];
			b_nxt = ph_nxt[1] ^ ph_nxt[0];
		end else begin
			a_nxt = ph_nxt[1] ^ ph_nxt[0];
			b_nxt = ph_nxt[1];
		end
	end

	// Index window follows the next full A pulse after the index
	always_comb begin
		z_state_nxt = z_state_r;
		case (z_state_r)
			Z_IDLE: begin
				if (index_evt && per_rev_r) begin
					z_state_nxt = Z_ARMED;
				end
			end
			Z_ARMED: begin
				// [R4] open with A rising
				if (a_nxt && !a_r) begin
					z_state_nxt = Z_HIGH;
				end
			end
			Z_HIGH: begin
				// [R4] close with A falling
				if (!a_nxt) begin
					z_state_nxt = Z_IDLE;
				end
			end
			default: begin
				z_state_nxt = Z_IDLE;
			end
		endcase
		// [R6] ratio mode takes the timer pulse
		z_nxt    = per_rev_r ? (z_state_nxt == Z_HIGH) : z_async;
		// [R11] homing marker on shifted index
		home_nxt = index_evt;
		// [R13] forward command to CCW
		ccw_nxt  = forward_cmd_i ^ dir_sel_r;
	end

	// Asynchronous fixed-width index for ratio mode
	pulse_timer #(
		.WIDTH_CYC (Z_PULSE_CYCLES)
	) u_z_timer (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.trig_i    (index_evt && !per_rev_r),
		.pulse_o   (z_async)
	);

	// Output and tracking registers
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prev_r       <= '0;
			ph_r         <= 2'b00;
			a_r          <= 1'b0;
			b_r          <= 1'b0;
			z_state_r    <= Z_IDLE;
			z_r          <= 1'b0;
			home_index_o <= 1'b0;
			rotate_ccw_o <= 1'b0;
		end else begin
			prev_r       <= prev_nxt;
			ph_r         <= ph_nxt;
			a_r          <= a_nxt;
			b_r          <= b_nxt;
			z_state_r    <= z_state_nxt;
			z_r          <= z_nxt;
			home_index_o <= home_nxt;
			rotate_ccw_o <= ccw_nxt;
		end
	end

	// Differential pairs are the complement of one flop each
	assign quad_out_a_pos_o = a_r;
	assign quad_out_a_neg_o = ~a_r;
	assign quad_out_b_pos_o = b_r;
	assign quad_out_b_neg_o = ~b_r;
	assign index_out_pos_o  = z_r;
	assign index_out_neg_o  = ~z_r;
	assign home_ref_pos_o   = offs_r;
	assign cfg_ready_o      = loaded_r;

	// Sequences used by the phase order and index alignment checks
	sequence s_ccw_step_from_equal;
		div_step && div_ccw && (a_r == b_r);
	endsequence

	sequence s_z_opens;
		$rose(z_r) && per_rev_r;
	endsequence

	sequence s_a_rises;
		a_r && !$past(a_r);
	endsequence

	// [R2] held count within limits
	a_ppr_in_range: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R2]
		loaded_r |-> ppr_r >= PPR_MIN && ppr_r <= (is20_r ? PPR_MAX_20 : PPR_MAX_18))
		else $error("pulse count outside limits");

	// [R1] per-revolution increment and modulus
	a_per_rev_ratio: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R1]
		loaded_r && per_rev_r |-> inc_r == ACC_W'(ppr_r) * QUAD_EDGES &&
		mod_r == (is20_r ? RES_20 : RES_18))
		else $error("per-revolution divider set wrongly");

	// [R7] ratio never above one
	a_ratio_capped: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R7]
		loaded_r |-> inc_r <= mod_r && inc_r != '0)
		else $error("output ratio above one");

	// [R14] settings hold after load
	a_settings_held: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R14]
		loaded_r && $past(loaded_r) |-> $stable(inc_r) && $stable(mod_r) &&
		$stable(offs_r) && $stable(lead_r) && $stable(dir_sel_r))
		else $error("setting changed after load");

	// [R8] only one phase changes at a time
	a_quad_gray: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R8]
		!($changed(a_r) && $changed(b_r)))
		else $error("both phases changed together");

	// [R8] lead phase moves first at CCW
	a_lead_order: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R8]
		s_ccw_step_from_equal |=>
		((lead_r == LEAD_B_AT_CCW) ? $changed(b_r) : $changed(a_r)))
		else $error("wrong phase leads at CCW");

	// [R4] index opens with A rising
	a_z_with_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R4]
		s_z_opens |-> s_a_rises)
		else $error("index not aligned with A");

	// [R4] open index follows A until A falls
	a_z_in_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R4]
		per_rev_r && $past(z_r) |-> z_r == a_r)
		else $error("index width differs from A");

	// [R11] homing marker at offset position
	a_home_at_offset: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R11]
		home_index_o |-> prev_r == offs_r && home_ref_pos_o == offs_r)
		else $error("homing index not at offset");

	// [R13] direction mapping
	a_dir_map: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R13]
		loaded_r |=> rotate_ccw_o == ($past(forward_cmd_i) ^ dir_sel_r))
		else $error("rotation direction mapped wrongly");

endmodule // encoder_pulse_output_divider

// ### verification/quad_host_counter.sv
// Host side model: quadrature edge counter with index edge counter
`timescale 1ns/1ps
module quad_host_counter (
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_b_i,
	// Quadrature and index lines from the device
	input  wire logic quad_a_i,
	input  wire logic quad_b_i,
	input  wire logic index_i,
	// Counts seen by the host
	output int        count_o,
	output int        index_cnt_o,
	output int        bad_cnt_o
);
	logic a_r;
	logic b_r;
	logic z_r;

	// every edge counted
	// Both phases decoded, so one output pulse is four counts
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			a_r         <= 1'b0;
			b_r         <= 1'b0;
			z_r         <= 1'b0;
			count_o     <= 0;
			index_cnt_o <= 0;
			bad_cnt_o   <= 0;
		end else begin
			a_r <= quad_a_i;
			b_r <= quad_b_i;
			z_r <= index_i;
			// Both phases moving at once cannot be decoded
			if ((quad_a_i != a_r) && (quad_b_i != b_r))
				bad_cnt_o <= bad_cnt_o + 1;
			else if ((quad_a_i != a_r) || (quad_b_i != b_r))
				count_o <= count_o + ((quad_a_i ^ b_r) ? 1 : -1);
			if (index_i && !z_r)
				index_cnt_o <= index_cnt_o + 1;
		end
	end
endmodule // quad_host_counter

// ### verification/tb_top.sv
// Self-checking bench for the encoder pulse output stage
`timescale 1ns/1ps
module tb_top;
	import encoder_out_pkg::*;
	localparam int ZC = 20;

	logic               clk_sys_i = 1'b0;
	logic               rst_b_i = 1'b0;
	logic               en20 = 1'b1;
	logic [PPR_W-1:0]   ppr = PPR_DEFAULT;
	logic [RATIO_W-1:0] num = NUM_DEFAULT;
	logic [RATIO_W-1:0] den = DEN_DEFAULT;
	logic               lead_sel = 1'b0;
	logic [POS_W-1:0]   offs_in = '0;
	logic               dir_sel = 1'b0;
	logic [POS_W-1:0]   enc_pos = '0;
	logic               fwd = 1'b0;
	logic               a_p, a_n, b_p, b_n, z_p, z_n;
	logic [POS_W-1:0]   home_ref;
	logic               home_idx, rot_ccw, cfg_rdy;
	int                 cnt, zcnt, bad;
	int num_errors = 0;
	int checked = 0;
	int pos, acc, edges, inc, modv, msk, offs, exp_home, home_seen, zw;
	bit lead, ratio;

	encoder_pulse_output_divider #(.Z_PULSE_CYCLES(ZC)) dut (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .enc_is_20bit_i(en20),
		.output_pulses_per_rev_i(ppr), .output_ratio_numerator_i(num),
		.output_ratio_denominator_i(den), .ccw_phase_lead_select_i(lead_sel),
		.index_position_offset_i(offs_in), .rotation_direction_select_i(dir_sel),
		.enc_pos_i(enc_pos), .forward_cmd_i(fwd),
		.quad_out_a_pos_o(a_p), .quad_out_a_neg_o(a_n), .quad_out_b_pos_o(b_p),
		.quad_out_b_neg_o(b_n), .index_out_pos_o(z_p), .index_out_neg_o(z_n),
		.home_ref_pos_o(home_ref), .home_index_o(home_idx), .rotate_ccw_o(rot_ccw),
		.cfg_ready_o(cfg_rdy));

	quad_host_counter host (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .quad_a_i(a_p), .quad_b_i(b_p),
		.index_i(z_p), .count_o(cnt), .index_cnt_o(zcnt), .bad_cnt_o(bad));

	// Clock, 20 ns period
	initial begin
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Output monitor, sampled at the falling edge where outputs are settled
	always @(negedge clk_sys_i) begin
		if (!rst_b_i) begin
			home_seen = 0;
			zw = 0;
		end else begin
			check({a_n, b_n, z_n}, {~a_p, ~b_p, ~z_p});
			if (home_idx === 1'b1)
				home_seen++;
			if (!ratio && z_p === 1'b1)
				check(a_p, 1'b1);
			if (z_p === 1'b1)
				zw++;
			else if (zw > 0) begin
				// fixed index width; index ends with A
				if (ratio)
					check(zw, ZC);
				else
					check(a_p, 1'b0);
				zw = 0;
			end
		end
	end

	// Reset with settings applied; reference model follows the rules
	task automatic start(input bit e20, input int p, input int nu, input int de,
			input bit ld, input int of, input bit sel);
		int res;
		int pmax;
		@(negedge clk_sys_i);
		rst_b_i = 1'b0;
		en20 = e20;
		ppr = p[PPR_W-1:0];
		num = nu[RATIO_W-1:0];
		den = de[RATIO_W-1:0];
		lead_sel = ld;
		offs_in = of[POS_W-1:0];
		dir_sel = sel;
		enc_pos = '0;
		res = e20 ? 1048576 : 262144;
		pmax = e20 ? 262144 : 65536;
		msk = res - 1;
		pos = 0;
		acc = 0;
		edges = 0;
		exp_home = 0;
		lead = ld;
		ratio = (p == 0);
		offs = (of > msk) ? msk : of;
		if (ratio) begin
			inc = (nu > de) ? de : nu;
			modv = de;
		end else begin
			inc = 4 * ((p > pmax) ? pmax : ((p < 16) ? 16 : p));
			modv = res;
		end
		repeat (3) @(negedge clk_sys_i);
		rst_b_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		check(cfg_rdy, 1'b1);
		check(home_ref, offs[POS_W-1:0]);
	endtask

	// Move the encoder one count per clock, then compare host counts
	task automatic move(input int n, input bit ccw);
		repeat (n) begin
			@(negedge clk_sys_i);
			pos = (ccw ? pos + 1 : pos - 1) & msk;
			enc_pos = pos[POS_W-1:0];
			acc += ccw ? inc : -inc;
			if (acc >= modv) begin
				acc -= modv;
				edges++;
			end else if (acc < 0) begin
				acc += modv;
				edges--;
			end
			if (pos == offs)
				exp_home++;
		end
		repeat (4) @(negedge clk_sys_i);
		check(cnt, lead ? edges : -edges);
		check(home_seen, exp_home);
		check(bad, 0);
	endtask

	// Watchdog, about eight times the expected run length
	initial begin
		#200us;
		num_errors++;
		report_and_stop();
	end

	initial begin
		int k;
		void'($urandom(32'h579F));
		ratio = 1'b0;
		// Max count, B leads at CCW, index offset crossed both ways
		start(1, 262144, 1, 16, 0, 5 + $urandom_range(25), 0);
		move(40, 1);
		check(zcnt, 1);
		move(40, 0);
		// Clamped count, A leads, top offset reached going CW
		start(1, 300000, 1, 16, 1, 1048575, 0);
		move(40, 1);
		move(43, 0);
		// 18-bit clamp and offset clamp
		start(0, 100000, 1, 16, 0, 1048575, 0);
		move(50, 1);
		move(52, 0);
		// Fractional count per step
		start(0, 16384, 1, 16, 1, 0, 0);
		move(100 + $urandom_range(50), 1);
		// Ratio mode with direction select set
		start(1, 0, 1, 4, 0, 10 + $urandom_range(20), 1);
		move(100, 1);
		check(zcnt, 1);
		move(60, 0);
		// Numerator above denominator
		start(1, 0, 5, 3, 1, 0, 0);
		move(30, 1);
		// Late setting changes are ignored
		start(1, 2048, 1, 16, 0, 3, 0);
		ppr = 19'h40000;
		offs_in = 20'h00007;
		move(600, 1);
		check(home_ref, 20'h00003);
		// Forward command mapping for each select and command
		for (k = 0; k < 4; k++) begin
			start(1, 2048, 1, 16, 0, 0, k[1]);
			fwd = k[0];
			repeat (2) @(negedge clk_sys_i);
			check(rot_ccw, k[0] != k[1]);
		end
		report_and_stop();
	end
endmodule // tb_top
